// ==== fbcw_pkg.sv ====
/*
 * Shared constants, bit positions and carrier types for the fieldbus
 * command word decoder (legacy 16-bit profile, native 32-bit profile).
 * Assumes one clock domain; words are written by logic on that clock.
 */
`default_nettype none
package fbcw_pkg;
   localparam int LEGACY_W = 16;
   localparam int NATIVE_W = 32;
   localparam int REF_W = 32;
   localparam int DRIVE_CMD_W = 16;
   localparam int APP_W = 4;

   // Legacy word bit positions
   localparam int LEG_JOG2 = 9;
   localparam int LEG_BUS_CTRL = 10;
   localparam int LEG_LOC = 11;
   localparam int LEG_APP_LSB = 12;

   // Native word bit positions
   localparam int NAT_STOP = 0;
   localparam int NAT_START = 1;
   localparam int NAT_REVERSE = 2;
   localparam int NAT_FAULT_RESET = 4;
   localparam int NAT_LOC = 5;
   localparam int NAT_RUN_DISABLE = 6;
   localparam int NAT_STOP_RAMP = 7;
   localparam int NAT_STOP_EMERG = 8;
   localparam int NAT_STOP_FREE = 9;
   localparam int NAT_RAMP_OUT_ZERO = 11;
   localparam int NAT_RAMP_HOLD = 12;
   localparam int NAT_RAMP_IN_ZERO = 13;
   localparam int NAT_LOCAL_LOCK = 14;
   localparam int NAT_LOCAL_CTL = 16;
   localparam int NAT_LOCAL_SET = 17;
   localparam int NAT_APP_LSB = 22;

   // Implemented native bits; reserved ones are dropped at the latch
   localparam logic [NATIVE_W-1:0] NATIVE_IMPL_MASK = 32'h03C3_7BF7;
   localparam logic [LEGACY_W-1:0] LEGACY_IMPL_MASK = 16'hFFFF;
   localparam logic [REF_W-1:0] REF_IMPL_MASK = 32'hFFFF_FFFF;

   // Reset values
   localparam logic [LEGACY_W-1:0] LEGACY_RESET = 16'h0000;
   localparam logic [NATIVE_W-1:0] NATIVE_RESET = 32'h0000_0000;
   localparam logic [REF_W-1:0] REF_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      stop_sel_ramp = 3'b001,
      stop_sel_emergency = 3'b010,
      stop_sel_freewheel = 3'b100
   } stop_mode_t;

   // Configuration from drive parameters, same clock domain
   typedef struct packed {
      logic jog2_from_bus;
      logic location_from_bus;
      logic run_permit_from_bus;
      stop_mode_t param_stop_mode;
      logic fault_active;
   } drive_cfg_t;

   typedef struct packed {
      logic jog2_request;
      logic bus_control_enabled;
      logic ref_ramp_locked;
      logic location_valid;
      logic external_location_b;
      logic [APP_W-1:0] app_bits;
   } legacy_cmd_t;

   typedef struct packed {
      logic [DRIVE_CMD_W-1:0] drive_command;
      logic stop_request;
      logic start_request;
      logic reverse_request;
      logic fault_reset_pulse;
      logic location_valid;
      logic external_location_b;
      logic run_permit;
      stop_mode_t stop_mode;
      logic ramp_out_zero;
      logic ramp_hold;
      logic ramp_in_zero;
      logic local_lock_request;
      logic bus_local_control_request;
      logic bus_local_setpoint_request;
      logic [APP_W-1:0] app_bits;
   } native_cmd_t;
endpackage
`default_nettype wire

// ==== word_latch.sv ====
/*
 * Whole-word command latch: loads every implemented bit in one cycle.
 * Assumes load is a one-cycle strobe on mclk with data valid alongside.
 */
`default_nettype none
module word_latch #(
   parameter int W = 16,
   parameter logic [W-1:0] MASK = '1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic load,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] word;
   } latch_state_t;

   latch_state_t state;
   latch_state_t next_state;

   // All bits change together so dout never presents a mixed word
   always_comb begin
      next_state = state;
      if (load) begin
         next_state.word = din & MASK;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state.word <= RST;
      end else begin
         state <= next_state;
      end
   end

   assign dout = state.word;
endmodule
`default_nettype wire

// ==== rise_detect.sv ====
/*
 * Rising-edge detector for levels held in command registers.
 * Assumes the level is already synchronous to mclk.
 */
`default_nettype none
module rise_detect #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [W-1:0] level,
   output logic [W-1:0] rise
);
   typedef struct packed {
      logic [W-1:0] prev;
   } edge_state_t;

   edge_state_t state;
   edge_state_t next_state;

   // Remember last level each cycle
   always_comb begin
      next_state = state;
      next_state.prev = level;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state.prev <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign rise = level & ~state.prev;
endmodule
`default_nettype wire

// ==== fieldbus_control_word_decoder.sv ====
/*
 * Fieldbus command word decoder for a motor drive. Latches the legacy
 * 16-bit word (with its reference) and the native 32-bit word, and
 * decodes them into registered command outputs.
 * Assumes the fieldbus interface logic and drive parameters share mclk,
 * so no input is synchronised here.
 */
`default_nettype none
module fieldbus_control_word_decoder (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic legacy_wr,
   input wire logic [fbcw_pkg::LEGACY_W-1:0] legacy_wdata,
   input wire logic [fbcw_pkg::REF_W-1:0] legacy_ref_wdata,
   input wire logic native_wr,
   input wire logic [fbcw_pkg::NATIVE_W-1:0] native_wdata,
   input wire fbcw_pkg::drive_cfg_t cfg,
   output logic [fbcw_pkg::LEGACY_W-1:0] legacy_word_rd,
   output logic [fbcw_pkg::REF_W-1:0] legacy_ref_rd,
   output logic [fbcw_pkg::NATIVE_W-1:0] native_word_rd,
   output logic legacy_write_refused,
   output fbcw_pkg::legacy_cmd_t legacy_cmd,
   output fbcw_pkg::native_cmd_t native_cmd
);
   import fbcw_pkg::*;

   typedef struct packed {
      legacy_cmd_t leg;
      native_cmd_t nat;
      logic refused;
   } dec_state_t;

   dec_state_t state;
   dec_state_t next_state;

   logic legacy_accept;
   logic legacy_all_zero;
   logic [LEGACY_W-1:0] leg_word;
   logic [REF_W-1:0] leg_ref;
   logic [NATIVE_W-1:0] nat_word;
   logic fault_reset_rise;
   logic [LEGACY_W-1:0] legacy_seen_word;

   // A write with control disabled and live data is dropped, which keeps
   // the last word and reference in force on a bus that lost its master
   assign legacy_all_zero = (legacy_wdata == LEGACY_RESET) &&
      (legacy_ref_wdata == REF_RESET);
   assign legacy_accept = legacy_wr &&
      (legacy_wdata[LEG_BUS_CTRL] || legacy_all_zero);

   word_latch #(
      .W(LEGACY_W),
      .MASK(LEGACY_IMPL_MASK),
      .RST(LEGACY_RESET)
   ) u_legacy_word (
      .mclk(mclk),
      .resetn(resetn),
      .load(legacy_accept),
      .din(legacy_wdata),
      .dout(leg_word)
   );

   word_latch #(
      .W(REF_W),
      .MASK(REF_IMPL_MASK),
      .RST(REF_RESET)
   ) u_legacy_ref (
      .mclk(mclk),
      .resetn(resetn),
      .load(legacy_accept),
      .din(legacy_ref_wdata),
      .dout(leg_ref)
   );

   word_latch #(
      .W(NATIVE_W),
      .MASK(NATIVE_IMPL_MASK),
      .RST(NATIVE_RESET)
   ) u_native_word (
      .mclk(mclk),
      .resetn(resetn),
      .load(native_wr),
      .din(native_wdata),
      .dout(nat_word)
   );

   // Edge on the stored bit, so holding it high never repeats a reset
   rise_detect #(
      .W(1)
   ) u_fault_reset_edge (
      .mclk(mclk),
      .resetn(resetn),
      .level(nat_word[NAT_FAULT_RESET]),
      .rise(fault_reset_rise)
   );

   assign legacy_seen_word = leg_word;

   // Legacy profile decode, bits 9 to 15 only
   always_comb begin
      next_state = state;
      next_state.refused = legacy_wr && !legacy_accept;
      next_state.leg.jog2_request = cfg.jog2_from_bus &&
         legacy_seen_word[LEG_JOG2];
      if (legacy_accept) begin
         // Both accepted cases enable bus control
         next_state.leg.bus_control_enabled = 1'b1;
         next_state.leg.ref_ramp_locked =
            !legacy_wdata[LEG_BUS_CTRL];
      end
      next_state.leg.location_valid = cfg.location_from_bus;
      next_state.leg.external_location_b = cfg.location_from_bus &&
         legacy_seen_word[LEG_LOC];
      next_state.leg.app_bits =
         legacy_seen_word[LEG_APP_LSB +: APP_W];

      // Native profile decode
      next_state.nat.drive_command =
         nat_word[DRIVE_CMD_W-1:0];
      next_state.nat.stop_request = nat_word[NAT_STOP];
      next_state.nat.start_request = nat_word[NAT_START];
      next_state.nat.reverse_request = nat_word[NAT_REVERSE];
      next_state.nat.fault_reset_pulse = fault_reset_rise &&
         cfg.fault_active;
      next_state.nat.location_valid = cfg.location_from_bus;
      next_state.nat.external_location_b = cfg.location_from_bus &&
         nat_word[NAT_LOC];
      // Bus does not block running unless it owns the permit
      next_state.nat.run_permit = !(cfg.run_permit_from_bus &&
         nat_word[NAT_RUN_DISABLE]);
      // Several request bits at once: the harder stop wins
      if (nat_word[NAT_STOP_FREE]) begin
         next_state.nat.stop_mode = stop_sel_freewheel;
      end else if (nat_word[NAT_STOP_EMERG]) begin
         next_state.nat.stop_mode = stop_sel_emergency;
      end else if (nat_word[NAT_STOP_RAMP]) begin
         next_state.nat.stop_mode = stop_sel_ramp;
      end else begin
         next_state.nat.stop_mode = cfg.param_stop_mode;
      end
      next_state.nat.ramp_out_zero = nat_word[NAT_RAMP_OUT_ZERO];
      next_state.nat.ramp_hold = nat_word[NAT_RAMP_HOLD];
      next_state.nat.ramp_in_zero = nat_word[NAT_RAMP_IN_ZERO];
      next_state.nat.local_lock_request =
         nat_word[NAT_LOCAL_LOCK];
      next_state.nat.bus_local_control_request =
         nat_word[NAT_LOCAL_CTL];
      next_state.nat.bus_local_setpoint_request =
         nat_word[NAT_LOCAL_SET];
      next_state.nat.app_bits = nat_word[NAT_APP_LSB +: APP_W];
   end

   // Decoded commands register one cycle after the word latch; bus_control_enabled and ref_ramp_locked load on the same edge as it
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state.leg <= '0;
         state.nat <= '0;
         state.nat.run_permit <= 1'b1;
         state.nat.stop_mode <= stop_sel_ramp;
         state.refused <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // Outputs all come from registers
   assign legacy_word_rd = leg_word;
   assign legacy_ref_rd = leg_ref;
   assign native_word_rd = nat_word;
   assign legacy_write_refused = state.refused;
   assign legacy_cmd = state.leg;
   assign native_cmd = state.nat;
endmodule
`default_nettype wire

// ==== fbcw_assertions.sv ====
/* Checker for the fieldbus command word decoder, bound to its ports.
   Assumes one clock, mclk, and the async active-low reset resetn. */
`default_nettype none
module fbcw_assertions (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic legacy_wr,
   input wire logic [15:0] legacy_wdata,
   input wire logic [31:0] legacy_ref_wdata,
   input wire logic native_wr,
   input wire logic [31:0] native_wdata,
   input wire fbcw_pkg::drive_cfg_t cfg,
   input wire logic [15:0] legacy_word_rd,
   input wire logic [31:0] native_word_rd,
   input wire logic legacy_write_refused,
   input wire fbcw_pkg::legacy_cmd_t legacy_cmd,
   input wire fbcw_pkg::native_cmd_t native_cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   import fbcw_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   drive_cfg_t pc;
   logic [31:0] pw;
   logic pf;
   // Stored word and cfg one edge back; reset holds words at zero
   always_ff @(posedge mclk) begin
      pc <= cfg;
      pw <= native_word_rd;
      pf <= pw[4];
   end
   sequence s_leg_bad;
      legacy_wr && !legacy_wdata[10]
         && (legacy_wdata != 16'h0 || legacy_ref_wdata != 32'h0);
   endsequence
   sequence s_leg_ok;
      legacy_wr && legacy_wdata[10];
   endsequence
   // Refusal flag registers on the strobe edge, beside the untouched word
   property p_leg_refuse;
      s_leg_bad |=> $stable(legacy_word_rd) && legacy_write_refused;
   endproperty
   a_leg_refuse: assert property (p_leg_refuse) else $error("refuse");
   property p_leg_take;
      s_leg_ok |=> legacy_word_rd == $past(legacy_wdata)
         ##1 legacy_cmd.bus_control_enabled;
   endproperty
   a_leg_take: assert property (p_leg_take) else $error("take");
   property p_jog_app;
      {legacy_cmd.jog2_request, legacy_cmd.app_bits} ==
         {$past(cfg.jog2_from_bus && legacy_word_rd[9]),
          $past(legacy_word_rd[15:12])};
   endproperty
   a_jog_app: assert property (p_jog_app) else $error("jog");
   property p_nat_word;
      native_wr |=> native_word_rd == ($past(native_wdata) & NATIVE_IMPL_MASK);
   endproperty
   a_nat_word: assert property (p_nat_word) else $error("word");
   property p_nat_cp;
      {native_cmd.drive_command, native_cmd.stop_request,
       native_cmd.start_request, native_cmd.reverse_request}
         == {pw[15:0], pw[0], pw[1], pw[2]};
   endproperty
   a_nat_cp: assert property (p_nat_cp) else $error("copy");
   property p_fault;
      native_cmd.fault_reset_pulse == (pw[4] && !pf && pc.fault_active);
   endproperty
   a_fault: assert property (p_fault) else $error("fault");
   property p_permit;
      {native_cmd.run_permit, native_cmd.external_location_b} ==
         {!(pc.run_permit_from_bus && pw[6]), pc.location_from_bus && pw[5]};
   endproperty
   a_permit: assert property (p_permit) else $error("perm");
   property p_stop_dflt;
      pw[9:7] == 3'h0 |-> native_cmd.stop_mode == pc.param_stop_mode;
   endproperty
   a_stop_dflt: assert property (p_stop_dflt) else $error("dflt");
   property p_stop_free;
      pw[9] |-> native_cmd.stop_mode == stop_sel_freewheel;
   endproperty
   a_stop_free: assert property (p_stop_free) else $error("coast");
endmodule
bind fieldbus_control_word_decoder fbcw_assertions chk (.*);
`default_nettype wire

// ==== fb_master_model.sv ====
/* Fieldbus master model: writes whole command words, one per strobe.
   Assumes the bench calls its tasks; signals change after rising edges. */
`default_nettype none
module fb_master_model (
   input wire logic mclk,
   output logic legacy_wr,
   output logic [15:0] legacy_wdata,
   output logic [31:0] legacy_ref_wdata,
   output logic native_wr,
   output logic [31:0] native_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle lines start low
   initial begin
      legacy_wr = 1'h0;
      legacy_wdata = 16'h0;
      legacy_ref_wdata = 32'h0;
      native_wr = 1'h0;
      native_wdata = 32'h0;
   end
   // Word and reference go out together; stale data is inverted
   task automatic wr_leg(input logic [15:0] w, input logic [31:0] r);
      @(posedge mclk);
      legacy_wr <= 1'h1;
      legacy_wdata <= w;
      legacy_ref_wdata <= r;
      @(posedge mclk);
      legacy_wr <= 1'h0;
      legacy_wdata <= ~w;
      legacy_ref_wdata <= ~r;
   endtask
   // Whole native word in one strobe
   task automatic wr_nat(input logic [31:0] w);
      @(posedge mclk);
      native_wr <= 1'h1;
      native_wdata <= w;
      @(posedge mclk);
      native_wr <= 1'h0;
      native_wdata <= ~w;
   endtask
endmodule
`default_nettype wire

// ==== fieldbus_control_word_decoder_tb.sv ====
/* Self-checking bench for the fieldbus command word decoder.
   Assumes fb_master_model writes words and the checker is bound. */
`default_nettype none
module fieldbus_control_word_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fbcw_pkg::*;
   logic mclk = 1'h0;
   logic resetn = 1'h0;
   logic legacy_wr, native_wr, legacy_write_refused;
   logic [15:0] legacy_wdata, legacy_word_rd;
   logic [31:0] legacy_ref_wdata, native_wdata;
   logic [31:0] legacy_ref_rd, native_word_rd;
   drive_cfg_t cfg;
   legacy_cmd_t legacy_cmd;
   native_cmd_t native_cmd;
   int num_errors = 0;
   int comparisons = 0;
   stop_mode_t sm [4] = '{stop_sel_emergency, stop_sel_ramp,
                          stop_sel_emergency, stop_sel_freewheel};
   always #2.5 mclk = ~mclk;
   fb_master_model bus (.*);
   fieldbus_control_word_decoder dut (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Decoded outputs land two edges after the strobe
   task automatic settle;
      @(posedge mclk);
      #1;
   endtask
   task automatic final_report;
      if (num_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Whole run is about 42 cycles, well inside the 4000-cycle timeout
   initial begin
      #20000;
      num_errors++;
      final_report;
   end
   initial begin
      cfg = '{1'h1, 1'h1, 1'h1, stop_sel_ramp, 1'h1};
      repeat (4) @(posedge mclk);
      resetn <= 1'h1;
      settle;
      chk(native_word_rd, 32'h0);
      chk({native_cmd.run_permit, native_cmd.stop_mode}, 4'h9);
      bus.wr_nat(32'hFFFF_FFFF);
      settle;
      chk(native_word_rd, NATIVE_IMPL_MASK);
      chk(native_cmd.drive_command, 16'h7BF7);
      chk({native_cmd.stop_request, native_cmd.start_request,
           native_cmd.reverse_request}, 3'h7);
      chk(native_cmd.fault_reset_pulse, 1'h1);
      chk({native_cmd.location_valid, native_cmd.external_location_b,
           native_cmd.run_permit}, 3'h6);
      chk(native_cmd.stop_mode, stop_sel_freewheel);
      chk({native_cmd.ramp_out_zero, native_cmd.ramp_hold,
           native_cmd.ramp_in_zero}, 3'h7);
      chk({native_cmd.local_lock_request, native_cmd.app_bits,
           native_cmd.bus_local_control_request,
           native_cmd.bus_local_setpoint_request},
          7'h7F);
      settle;
      chk(native_cmd.fault_reset_pulse, 1'h0);
      bus.wr_nat(32'h10);
      settle;
      chk({native_cmd.fault_reset_pulse, native_cmd.drive_command},
          17'h10);
      cfg.param_stop_mode <= stop_sel_emergency;
      for (int i = 0; i < 4; i++) begin
         bus.wr_nat(i == 0 ? 32'h1 : 32'h1 | (32'h1 << (6 + i)));
         settle;
         chk(native_cmd.stop_mode, sm[i]);
      end
      cfg.fault_active <= 1'h0;
      bus.wr_nat(32'h10);
      settle;
      chk(native_cmd.fault_reset_pulse, 1'h0);
      bus.wr_leg(16'hFE00, 32'h1234_5678);
      settle;
      chk(legacy_word_rd, 32'hFE00);
      chk(legacy_ref_rd, 32'h1234_5678);
      chk({legacy_cmd.jog2_request, legacy_cmd.bus_control_enabled,
           legacy_cmd.ref_ramp_locked, legacy_cmd.location_valid,
           legacy_cmd.external_location_b, legacy_cmd.app_bits},
          9'h1BF);
      bus.wr_leg(16'h0200, 32'h0);
      // Refusal is a one-cycle pulse straight after the strobe edge
      #1;
      chk({legacy_write_refused, legacy_word_rd}, 17'h1FE00);
      settle;
      chk({legacy_write_refused, legacy_word_rd}, 17'h0FE00);
      bus.wr_leg(16'h0, 32'h0);
      settle;
      chk({legacy_write_refused, legacy_cmd.bus_control_enabled,
           legacy_cmd.ref_ramp_locked}, 3'h3);
      cfg.location_from_bus <= 1'h0;
      cfg.run_permit_from_bus <= 1'h0;
      cfg.jog2_from_bus <= 1'h0;
      bus.wr_nat(32'h60);
      settle;
      chk({native_cmd.location_valid, native_cmd.external_location_b,
           native_cmd.run_permit}, 3'h1);
      // Jog and location bits must be ignored once the bus does not own them
      bus.wr_leg(16'hFE00, 32'h0);
      settle;
      chk({legacy_cmd.jog2_request, legacy_cmd.location_valid,
           legacy_cmd.external_location_b}, 3'h0);
      final_report;
   end
endmodule
`default_nettype wire
